/* inc/rcl_map.vh */
// Register offsets, field positions, reset values and timing figures for the cycle limiter
`ifndef RCL_MAP_VH
`define RCL_MAP_VH

// Register offsets
`define RCL_OFS_LIMIT_LOW      8'h48
`define RCL_OFS_RISE_OFFSET    8'h49

// Field positions
`define RCL_LIMIT_NIB_HI       7
`define RCL_LIMIT_NIB_LO       4
`define RCL_OFFSET_SIGN_BIT    7

// Reset values
`define RCL_LIMIT_LOW_RST      8'h00
`define RCL_RISE_OFFSET_RST    8'h00
`define RCL_RDATA_UNMAPPED     8'h00

// Timing, in ns, except RCL_LEAD_SPAN, which counts 5 ns units
`define RCL_UNIT_NS            16'h0005
`define RCL_CLK_PERIOD_NS      17'h00004
`define RCL_LEAD_SPAN          9'h100
`define RCL_NS_ZERO            16'h0000

`endif

/* hdl/rcl_cycle_gen.v */
// Resonant-mode minimum cycle limit and third output rising-edge offset generator
//
// Operation
// - Limit-low upper nibble holds four limit LSBs
// - Limit is high register then this nibble
// - Each limit unit is 5 ns period
// - Never switch faster than the minimum cycle
// - Rise offset applies only in resonant mode
// - Offset register steps rise by 5 ns
// - Codes 0x00-0x7F: rise trails the midpoint
// - Codes 0x80-0xFF: rise leads the midpoint
// - Lead equals 256 minus code, times 5 ns
`timescale 1ns/1ps
`include "rcl_map.vh"

module rcl_cycle_gen
(
   input wire core_clk_i,                 // 250 MHz core clock
   input wire sys_rst_i,                  // Synchronous reset, active high
   input wire ce_i,                       // Clock enable, freezes all state when low
   input wire [7:0] reg_addr_i,           // Register offset
   input wire reg_wr_i,                   // Register write strobe
   input wire [7:0] reg_wdata_i,          // Register write data
   input wire reg_rd_i,                   // Register read strobe
   output reg [7:0] reg_rdata_o,          // Register read data
   input wire [7:0] limit_high_i,         // Eight MSBs of cycle limit, companion register
   input wire [11:0] period_req_i,        // Requested period from the loop, 5 ns units
   input wire resonant_mode_i,            // Resonant mode active
   output reg third_switch_output_o,      // Third switch drive output
   output reg cycle_start_o,              // One-cycle pulse at each switching cycle start
   output reg [15:0] cycle_period_ns_o    // Period in force for the current cycle, ns
);

   // ************************************************************
   // Helpers
   // ************************************************************
   function [15:0] units_to_ns;
      input [11:0] units;
      begin
         units_to_ns = {4'h0, units} * `RCL_UNIT_NS;
      end
   endfunction

   // ************************************************************
   // Address decode
   // ************************************************************
   localparam SEL_LIMIT = 0;
   localparam SEL_OFFSET = 1;

   // One select bit per mapped register, shared by write and read paths
   function [1:0] reg_sel;
      input [7:0] addr;
      begin
         reg_sel = 2'h0;
         if (addr == `RCL_OFS_LIMIT_LOW)
         begin
            reg_sel[SEL_LIMIT] = 1'b1;
         end
         if (addr == `RCL_OFS_RISE_OFFSET)
         begin
            reg_sel[SEL_OFFSET] = 1'b1;
         end
      end
   endfunction

   // ************************************************************
   // Registers
   // ************************************************************
   reg [7:0] limit_low_r;
   reg [7:0] rise_offset_r;
   reg [7:0] rd_mux;
   wire [1:0] wr_sel;
   wire [1:0] rd_sel;

   assign wr_sel = reg_wr_i ? reg_sel(reg_addr_i) : 2'h0;
   assign rd_sel = reg_sel(reg_addr_i);

   always @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         limit_low_r <= `RCL_LIMIT_LOW_RST;
      end
      else if (ce_i && wr_sel[SEL_LIMIT])
      begin
         // Reserved low nibble is stored so it reads back as written
         limit_low_r <= reg_wdata_i;
      end
   end

   always @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         rise_offset_r <= `RCL_RISE_OFFSET_RST;
      end
      else if (ce_i && wr_sel[SEL_OFFSET])
      begin
         rise_offset_r <= reg_wdata_i;
      end
   end

   // Read returns the value held before a same-cycle write
   always @*
   begin
      rd_mux = `RCL_RDATA_UNMAPPED;
      if (rd_sel[SEL_LIMIT])
      begin
         rd_mux = limit_low_r;
      end
      else if (rd_sel[SEL_OFFSET])
      begin
         rd_mux = rise_offset_r;
      end
   end

   always @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         reg_rdata_o <= `RCL_RDATA_UNMAPPED;
      end
      else if (ce_i && reg_rd_i)
      begin
         reg_rdata_o <= rd_mux;
      end
   end

   // ************************************************************
   // Period selection
   // ************************************************************
   wire [11:0] limit_units;
   wire [11:0] eff_units;
   wire [15:0] eff_ns;

   // Reserved nibble is never read into the timing path
   assign limit_units = {limit_high_i,
                         limit_low_r[`RCL_LIMIT_NIB_HI:`RCL_LIMIT_NIB_LO]};
   assign eff_units = (period_req_i < limit_units) ? limit_units : period_req_i;
   assign eff_ns = units_to_ns(eff_units);

   // ************************************************************
   // Rising edge placement
   // ************************************************************
   reg [16:0] rise_calc;
   reg [15:0] rise_ns;
   wire [8:0] lead_units;
   wire [15:0] trail_ns;
   wire [15:0] lead_ns;
   wire [15:0] mid_ns;

   assign mid_ns = {1'b0, eff_ns[15:1]};
   assign lead_units = `RCL_LEAD_SPAN - {1'b0, rise_offset_r};
   assign trail_ns = units_to_ns({4'h0, rise_offset_r});
   assign lead_ns = units_to_ns({3'h0, lead_units});

   always @*
   begin
      if (!resonant_mode_i)
      begin
         rise_calc = {1'b0, mid_ns};
      end
      else if (rise_offset_r[`RCL_OFFSET_SIGN_BIT])
      begin
         rise_calc = {1'b0, mid_ns} - {1'b0, lead_ns};
      end
      else
      begin
         rise_calc = {1'b0, mid_ns} + {1'b0, trail_ns};
      end
      // Clamp into the cycle so a large lead or trail never wraps
      if (rise_calc[16] && rise_offset_r[`RCL_OFFSET_SIGN_BIT] && resonant_mode_i)
      begin
         rise_ns = `RCL_NS_ZERO;
      end
      else if (rise_calc[15:0] > eff_ns)
      begin
         rise_ns = eff_ns;
      end
      else
      begin
         rise_ns = rise_calc[15:0];
      end
   end

   // ************************************************************
   // Cycle timer
   // ************************************************************
   reg [15:0] t_ns_r;
   reg [15:0] period_ns_r;
   reg [15:0] rise_ns_r;
   wire [16:0] t_next;
   wire cycle_end;

   assign t_next = {1'b0, t_ns_r} + `RCL_CLK_PERIOD_NS;
   // A zero period after reset ends the first cycle at once and loads settings
   // End only once the full period has elapsed, rounding up to whole clocks
   assign cycle_end = (t_next >= {1'b0, period_ns_r});

   always @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         t_ns_r <= `RCL_NS_ZERO;
         period_ns_r <= `RCL_NS_ZERO;
         rise_ns_r <= `RCL_NS_ZERO;
         third_switch_output_o <= 1'b0;
         cycle_start_o <= 1'b0;
         cycle_period_ns_o <= `RCL_NS_ZERO;
      end
      else if (ce_i)
      begin
         cycle_start_o <= cycle_end;
         if (cycle_end)
         begin
            // Settings are sampled once per cycle so edges stay consistent
            t_ns_r <= `RCL_NS_ZERO;
            period_ns_r <= eff_ns;
            rise_ns_r <= rise_ns;
            cycle_period_ns_o <= eff_ns;
            third_switch_output_o <= (rise_ns == `RCL_NS_ZERO) && (eff_ns != `RCL_NS_ZERO);
         end
         else
         begin
            t_ns_r <= t_next[15:0];
            third_switch_output_o <= (t_next[15:0] >= rise_ns_r);
         end
      end
   end

endmodule

/* tb/rcl_monitor.sv */
// Port checker for the cycle limiter
`timescale 1ns/1ps
module rcl_monitor
(
   input wire core_clk_i, // Core clock
   input wire sys_rst_i, // Synchronous reset
   input wire ce_i, // Clock enable
   input wire [7:0] reg_addr_i, // Register offset
   input wire reg_wr_i, // Write strobe
   input wire [7:0] reg_wdata_i, // Write data
   input wire reg_rd_i, // Read strobe
   input wire [7:0] reg_rdata_o, // Read data
   input wire third_switch_output_o, // Third switch drive
   input wire [15:0] cycle_period_ns_o // Period in force
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_rd(a);
      ce_i && reg_rd_i && !reg_wr_i && reg_addr_i == a;
   endsequence
   property p_wb(a);
      logic [7:0] d;
      (ce_i && reg_wr_i && reg_addr_i == a, d = reg_wdata_i) ##1 s_rd(a) |=> reg_rdata_o == d;
   endproperty
   chk_limit_read_back: assert property (p_wb(8'h48)) else $error("limit readback");
   chk_offset_read_back: assert property (p_wb(8'h49)) else $error("offset readback");
   chk_unmapped_zero: assert property
      (ce_i && reg_rd_i && reg_addr_i[7:1] != 7'h24 |=> reg_rdata_o == 8'h00) else $error("unmapped");
   chk_reset_clear: assert property
      (disable iff (1'b0) sys_rst_i |=> reg_rdata_o == 8'h00 && !third_switch_output_o)
      else $error("reset");
   chk_rdata_hold: assert property
      (!(ce_i && reg_rd_i) |=> $stable(reg_rdata_o)) else $error("rdata hold");
   chk_ce_freeze: assert property
      (!ce_i |=> $stable(third_switch_output_o) && $stable(cycle_period_ns_o)) else $error("freeze");
   chk_period_grid: assert property
      (cycle_period_ns_o % 16'h0005 == 16'h0000) else $error("period not on 5 ns grid");
   chk_zero_low: assert property
      (third_switch_output_o |-> cycle_period_ns_o != 16'h0000) else $error("zero period");
endmodule
bind rcl_cycle_gen rcl_monitor u_mon (
   .core_clk_i(core_clk_i),
   .sys_rst_i(sys_rst_i),
   .ce_i(ce_i),
   .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i),
   .reg_wdata_i(reg_wdata_i),
   .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o),
   .third_switch_output_o(third_switch_output_o),
   .cycle_period_ns_o(cycle_period_ns_o)
);

/* tb/rcl_stage_model.sv */
// Power stage model: counts drive-high clocks in each switching cycle
`timescale 1ns/1ps
module rcl_stage_model
(
   input wire clk_i, // clk
   input wire drive_i, // third switch drive
   input wire start_i, // cycle start pulse
   output reg [15:0] hi_cnt_o = 16'h0000 // high clocks of last cycle
);
   reg [15:0] acc_r = 16'h0000;
   always @(posedge clk_i)
   begin
      if (start_i)
      begin
         hi_cnt_o <= acc_r;
         acc_r <= {15'h0000, drive_i};
      end
      else
         acc_r <= acc_r + drive_i;
   end
endmodule

/* tb/rcl_cycle_gen_test.sv */
// Self-checking bench for the cycle limiter
`timescale 1ns/1ps
module rcl_cycle_gen_test;
   reg core_clk_i = 1'h0;
   reg sys_rst_i = 1'h1;
   reg ce_i = 1'h1;
   reg [7:0] reg_addr_i = 8'h00;
   reg reg_wr_i = 1'h0;
   reg [7:0] reg_wdata_i = 8'h00;
   reg reg_rd_i = 1'h0;
   reg [7:0] limit_high_i = 8'h00;
   reg [11:0] period_req_i = 12'h000;
   reg resonant_mode_i = 1'h1;
   wire [7:0] reg_rdata_o;
   wire third_switch_output_o;
   wire cycle_start_o;
   wire [15:0] cycle_period_ns_o;
   wire [15:0] hi_cnt;
   integer n_mismatch = 0;
   integer checks = 0;
   integer i;
   reg [7:0] codes [0:4];
   always #2 core_clk_i = ~core_clk_i;
   rcl_cycle_gen DUT (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .limit_high_i(limit_high_i),
      .period_req_i(period_req_i), .resonant_mode_i(resonant_mode_i),
      .third_switch_output_o(third_switch_output_o), .cycle_start_o(cycle_start_o),
      .cycle_period_ns_o(cycle_period_ns_o));
   rcl_stage_model u_stage (.clk_i(core_clk_i), .drive_i(third_switch_output_o),
      .start_i(cycle_start_o), .hi_cnt_o(hi_cnt));
   task tick;
   begin
      @(posedge core_clk_i) #1;
   end
   endtask
   task chk(input [8*6:1] nm, input [15:0] e, input [15:0] g);
   begin
      checks = checks + 1;
      if (g !== e)
      begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   task wr(input [7:0] a, input [7:0] d);
   begin
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'h1;
      tick;
      reg_wr_i = 1'h0;
   end
   endtask
   task rdc(input [7:0] a, input [7:0] e);
   begin
      reg_addr_i = a;
      reg_rd_i = 1'h1;
      tick;
      reg_rd_i = 1'h0;
      chk("rdata", {8'h00, e}, {8'h00, reg_rdata_o});
   end
   endtask
   task settle;
   begin
      repeat (160) tick;
   end
   endtask
   function [15:0] exp_hi(input [7:0] c);
      integer r;
   begin
      r = (c < 8'h80) ? 100 + c * 5 : 100 - (256 - c) * 5;
      if (r < 0)
         r = 0;
      if (r > 200)
         r = 200;
      exp_hi = 50 - (r + 3) / 4;
   end
   endfunction
   task t_regs;
   begin
      wr(8'h48, 8'h9F);
      rdc(8'h48, 8'h9F);
      wr(8'h49, 8'hA5);
      rdc(8'h49, 8'hA5);
      tick;
      rdc(8'h4A, 8'h00);
   end
   endtask
   task t_limit;
   begin
      limit_high_i = 8'h01;
      period_req_i = 12'h00A;
      wr(8'h48, 8'h90);
      settle;
      chk("period", 16'h007D, cycle_period_ns_o);
      wr(8'h48, 8'h9F);
      settle;
      chk("period", 16'h007D, cycle_period_ns_o);
      period_req_i = 12'h028;
      settle;
      chk("period", 16'h00C8, cycle_period_ns_o);
   end
   endtask
   task t_offset;
   begin
      codes[0] = 8'h00;
      codes[1] = 8'h02;
      codes[2] = 8'h7F;
      codes[3] = 8'hFE;
      codes[4] = 8'h80;
      limit_high_i = 8'h00;
      wr(8'h48, 8'h00);
      tick;
      for (i = 0; i < 5; i = i + 1)
      begin
         wr(8'h49, codes[i]);
         settle;
         chk("high", exp_hi(codes[i]), hi_cnt);
      end
      resonant_mode_i = 1'h0;
      wr(8'h49, 8'h02);
      settle;
      chk("high", exp_hi(8'h00), hi_cnt);
   end
   endtask
   task conclude;
   begin
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask
   initial
   begin
      repeat (3) tick;
      sys_rst_i = 1'h0;
      t_regs;
      ce_i = 1'h0;
      repeat (4) tick;
      ce_i = 1'h1;
      t_limit;
      t_offset;
      conclude;
   end
   initial
   begin
      #40000;
      n_mismatch = n_mismatch + 1;
      conclude;
   end
endmodule
